// file: pkg/dim_seq_pkg.sv
// Overview of operation
// R1: Dim drive buffers the enable/dim input level.
// R2: Enable high: device enabled, dim switch on.
// R3: Enable low: device disabled, dim switch off.
// R4: Low over 32,000 switching cycles enters standby.
// R5: Re-enable after disable goes through soft start.
// R6: Floating enable input is treated as high.
// R7: Analog level below 0.1V turns output off.
// R8: Overvoltage forces both drives and fault low.
// R9: Overvoltage state holds until below hysteresis point.
// R10: String short check only in boost configuration.
// R11: Short declared after two cycles above threshold.
// R12: Short starts hiccup, dim drive held low.
// R13: Hiccup off time expiry attempts a restart.
// R14: Persisting short repeats the off/retry cycle.
// R15: Cleared short returns to normal regulation.
// R16: Die above 165C: standby and fault low.
// R17: No restart until die below 145C.
// R18: Hiccup off time is 16,000 switching cycles.
// R19: Fault flag is open drain, low on fault.
// R20: Low-duration count clears whenever enable is high.
// R21: Host treats low flag as fault, drives clean levels.
`default_nettype none
package dim_seq_pkg;

    // Register byte offsets
    localparam logic [4:0] OFS_CONTROL = 5'h00;
    localparam logic [4:0] OFS_SOFT_START = 5'h04;
    localparam logic [4:0] OFS_STATUS = 5'h08;
    localparam logic [4:0] OFS_EVENTS = 5'h0C;
    localparam logic [4:0] OFS_RETRIES = 5'h10;

    // Control fields
    localparam int CTRL_BOOST_BIT = 0;
    localparam int CTRL_SHORT_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;

    // Status fields
    localparam int STAT_ENABLE_BIT = 4;
    localparam int STAT_STANDBY_BIT = 5;
    localparam int STAT_FAULT_BIT = 6;

    // Sticky event bits
    localparam int EV_OVP_BIT = 0;
    localparam int EV_SHORT_BIT = 1;
    localparam int EV_THERMAL_BIT = 2;
    localparam int EV_STANDBY_BIT = 3;

    // Counts, in switching cycles
    localparam logic [15:0] STANDBY_CYCLES_DEF = 16'h7D00;
    localparam logic [15:0] HICCUP_CYCLES_DEF = 16'h3E80;
    localparam logic [1:0] SHORT_TICKS = 2'h2;
    localparam logic [15:0] SOFT_START_RESET = 16'h0040;

    // Sensed inputs, as they arrive from pads and comparators
    typedef struct packed {
        logic en_pin;
        logic en_float;
        logic analog_low;
        logic overvoltage_sense;
        logic ovp_clear;
        logic overcurrent;
        logic hot;
        logic cool;
        logic sw_tick;
    } sense_t;

    // Enable high, overvoltage and thermal comparators in their safe state
    localparam logic [8:0] SENSE_RESET = 9'h192;

    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_SOFT_START,
        ST_RUN,
        ST_DISABLED,
        ST_HICCUP,
        ST_OVP,
        ST_THERMAL
    } seq_state_t;

endpackage
`default_nettype wire

// file: rtl/led_dim_enable_fault_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module led_dim_enable_fault_sequencer
    import dim_seq_pkg::*;
#(
    parameter logic [15:0] STANDBY_CYCLES = STANDBY_CYCLES_DEF,
    parameter logic [15:0] HICCUP_CYCLES = HICCUP_CYCLES_DEF
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Avalon-MM slave
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Enable/dim pad and pad float detect
    input wire logic EN_DIM_PIN,
    input wire logic EN_DIM_FLOAT,
    // Analog comparator results
    input wire logic ANALOG_LEVEL_INPUT_LOW,
    input wire logic OVERVOLTAGE_SENSE,
    input wire logic OVERVOLTAGE_CLEAR,
    input wire logic STRING_OVERCURRENT,
    input wire logic TEMP_HOT,
    input wire logic TEMP_COOL,
    // One pulse per switching cycle from the oscillator
    input wire logic SWITCH_TICK,
    // Drives and mode outputs
    output logic POWER_SWITCH_DRIVE,
    output logic DIM_SWITCH_DRIVE,
    output logic SOFT_START_ACTIVE,
    output logic STANDBY_MODE,
    // Open-drain fault flag
    output logic FAULT_FLAG_N_OUT,
    output logic FAULT_FLAG_N_OE_N
);

    function automatic logic is_fault(input seq_state_t st);
        is_fault = (st == ST_OVP) || (st == ST_HICCUP) || (st == ST_THERMAL);
    endfunction

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = wd[8*i +: 8];
            end
        end
        merge_bytes = res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [8:0] sync1;
    logic [8:0] sync2;
    logic [8:0] sync3;
    logic [8:0] filt;
    logic tick_prev;
    sense_t s;
    logic en_eff;
    logic tick;

    // A bit moves only when the second and third stages agree
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            sync1 <= SENSE_RESET;
            sync2 <= SENSE_RESET;
            sync3 <= SENSE_RESET;
            filt <= SENSE_RESET;
        end else begin
            sync1 <= {EN_DIM_PIN, EN_DIM_FLOAT, ANALOG_LEVEL_INPUT_LOW, OVERVOLTAGE_SENSE,
                      OVERVOLTAGE_CLEAR, STRING_OVERCURRENT, TEMP_HOT, TEMP_COOL, SWITCH_TICK};
            sync2 <= sync1;
            sync3 <= sync2;
            filt <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            tick_prev <= 1'b0;
        end else begin
            tick_prev <= s.sw_tick;
        end
    end

    assign s = sense_t'(filt);
    assign tick = s.sw_tick & ~tick_prev;
    // An undriven pad rests on its pull-up
    assign en_eff = s.en_pin | s.en_float; // R6

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [1:0] ctrl;
    logic [15:0] ss_len;
    logic [3:0] events;
    logic [15:0] retries;
    logic ack;
    logic wr_go;
    logic boost_mode;
    logic short_en;

    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
    assign wr_go = AVS_WRITE & ack;
    assign boost_mode = ctrl[CTRL_BOOST_BIT];
    assign short_en = ctrl[CTRL_SHORT_EN_BIT];

    // One wait cycle lets read data settle in a flip-flop
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ack <= 1'b0;
        end else begin
            ack <= (AVS_READ | AVS_WRITE) & ~ack;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ctrl <= CTRL_RESET;
            ss_len <= SOFT_START_RESET;
        end else if (wr_go) begin
            if (AVS_ADDRESS == OFS_CONTROL) begin
                ctrl <= 2'(merge_bytes({30'h0, ctrl}, AVS_WRITEDATA, AVS_BYTEENABLE));
            end
            if (AVS_ADDRESS == OFS_SOFT_START) begin
                ss_len <= 16'(merge_bytes({16'h0, ss_len}, AVS_WRITEDATA, AVS_BYTEENABLE));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    seq_state_t state;
    seq_state_t next_state;
    logic [15:0] cycles;
    logic [1:0] oc_ticks;
    logic short_declared;
    logic hiccup_done;

    // Short check runs only in the soft-start and run states
    assign short_declared = boost_mode && short_en && s.overcurrent && tick // R10
                            && (oc_ticks >= SHORT_TICKS - 2'h1) // R11
                            && (state == ST_RUN || state == ST_SOFT_START);
    assign hiccup_done = tick && (cycles == HICCUP_CYCLES - 16'h1); // R18

    always_comb begin
        next_state = state;
        if (s.hot && state != ST_THERMAL) begin
            next_state = ST_THERMAL; // R16
        end else if (s.overvoltage_sense && state != ST_THERMAL && state != ST_OVP) begin
            next_state = ST_OVP; // R8
        end else begin
            unique case (state)
                ST_STANDBY: begin
                    if (en_eff) begin
                        next_state = ST_SOFT_START; // R5
                    end
                end
                ST_SOFT_START: begin
                    if (short_declared) begin
                        next_state = ST_HICCUP; // R14
                    end else if (!en_eff) begin
                        next_state = ST_DISABLED; // R3
                    end else if (cycles >= ss_len) begin
                        next_state = ST_RUN; // R15
                    end
                end
                ST_RUN: begin
                    if (short_declared) begin
                        next_state = ST_HICCUP; // R12
                    end else if (!en_eff) begin
                        next_state = ST_DISABLED; // R3
                    end
                end
                ST_DISABLED: begin
                    if (en_eff) begin
                        next_state = ST_SOFT_START; // R5
                    end else if (tick && cycles >= STANDBY_CYCLES) begin
                        next_state = ST_STANDBY; // R4
                    end
                end
                ST_HICCUP: begin
                    if (hiccup_done) begin
                        next_state = ST_SOFT_START; // R13
                    end
                end
                ST_OVP: begin
                    if (s.ovp_clear && !s.overvoltage_sense) begin
                        next_state = ST_STANDBY; // R9
                    end
                end
                ST_THERMAL: begin
                    if (s.cool) begin
                        next_state = ST_STANDBY; // R17
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            state <= ST_STANDBY;
        end else begin
            state <= next_state;
        end
    end

    // Shared switching-cycle counter; any state change restarts it
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            cycles <= 16'h0;
        end else if (next_state != state || en_eff && state == ST_DISABLED) begin
            cycles <= 16'h0; // R20
        end else if (tick && cycles != 16'hFFFF) begin
            cycles <= cycles + 16'h1;
        end
    end

    // Consecutive switching cycles spent above the short threshold
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            oc_ticks <= 2'h0;
        end else if (!s.overcurrent || next_state != state) begin
            oc_ticks <= 2'h0;
        end else if (tick && oc_ticks != 2'h3) begin
            oc_ticks <= oc_ticks + 2'h1; // R11
        end
    end

    // Retry count saturates so a stuck short cannot wrap it
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            retries <= 16'h0;
        end else if (hiccup_done && state == ST_HICCUP && retries != 16'hFFFF) begin
            retries <= retries + 16'h1; // R14
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Drives, taken from the next state so a fault blocks them at once

    logic next_power;

    always_comb begin
        next_power = (next_state == ST_RUN || next_state == ST_SOFT_START) && !s.analog_low; // R7
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            POWER_SWITCH_DRIVE <= 1'b0;
            DIM_SWITCH_DRIVE <= 1'b0;
            SOFT_START_ACTIVE <= 1'b0;
            STANDBY_MODE <= 1'b1;
            FAULT_FLAG_N_OE_N <= 1'b1;
        end else begin
            POWER_SWITCH_DRIVE <= next_power; // R8
            DIM_SWITCH_DRIVE <= next_power && en_eff; // R1 R2 R3 R12
            SOFT_START_ACTIVE <= next_state == ST_SOFT_START;
            STANDBY_MODE <= next_state == ST_STANDBY || next_state == ST_THERMAL; // R16
            FAULT_FLAG_N_OE_N <= !is_fault(next_state); // R19
        end
    end

    assign FAULT_FLAG_N_OUT = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Sticky events and read data

    logic [3:0] ev_set;

    assign ev_set[EV_OVP_BIT] = next_state == ST_OVP && state != ST_OVP;
    assign ev_set[EV_SHORT_BIT] = next_state == ST_HICCUP && state != ST_HICCUP;
    assign ev_set[EV_THERMAL_BIT] = next_state == ST_THERMAL && state != ST_THERMAL;
    assign ev_set[EV_STANDBY_BIT] = next_state == ST_STANDBY && state != ST_STANDBY;

    // Write one to clear; a fresh event in the same cycle stays set
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            events <= 4'h0;
        end else if (wr_go && AVS_ADDRESS == OFS_EVENTS && AVS_BYTEENABLE[0]) begin
            events <= (events & ~AVS_WRITEDATA[3:0]) | ev_set;
        end else begin
            events <= events | ev_set;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            AVS_READDATA <= 32'h0;
        end else if (AVS_READ && !ack) begin
            unique case (AVS_ADDRESS)
                OFS_CONTROL: AVS_READDATA <= {30'h0, ctrl};
                OFS_SOFT_START: AVS_READDATA <= {16'h0, ss_len};
                OFS_STATUS: AVS_READDATA <= {25'h0, is_fault(state), state == ST_STANDBY, en_eff, 1'b0, state};
                OFS_EVENTS: AVS_READDATA <= {28'h0, events};
                OFS_RETRIES: AVS_READDATA <= {16'h0, retries};
                default: AVS_READDATA <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    a_dim_follows_enable: assert property ( // R1
        state == ST_RUN && en_eff && !s.analog_low && !s.overvoltage_sense && !s.hot && !short_declared
        |=> DIM_SWITCH_DRIVE && POWER_SWITCH_DRIVE)
        else $error("dim drive not on while enabled");

    a_disable_dim_off: assert property ( // R3
        !en_eff |=> !DIM_SWITCH_DRIVE)
        else $error("dim drive on while enable low");

    a_standby_entry: assert property ( // R4
        state == ST_DISABLED && !en_eff && tick && cycles >= STANDBY_CYCLES && !s.overvoltage_sense && !s.hot
        |=> state == ST_STANDBY && STANDBY_MODE)
        else $error("standby not entered after long low");

    a_no_early_standby: assert property ( // R4
        state == ST_DISABLED && cycles < STANDBY_CYCLES |=> state != ST_STANDBY)
        else $error("standby entered too early");

    a_reenable_soft_start: assert property ( // R5
        state == ST_DISABLED && en_eff && !s.overvoltage_sense && !s.hot |=> state == ST_SOFT_START ##0 SOFT_START_ACTIVE)
        else $error("re-enable skipped soft start");

    a_analog_off: assert property ( // R7
        s.analog_low |=> !POWER_SWITCH_DRIVE && !DIM_SWITCH_DRIVE)
        else $error("output on with analog level low");

    a_ovp_forces_low: assert property ( // R8
        s.overvoltage_sense && !s.hot && state != ST_THERMAL
        |=> state == ST_OVP && !POWER_SWITCH_DRIVE && !DIM_SWITCH_DRIVE && !FAULT_FLAG_N_OE_N)
        else $error("overvoltage did not force drives low");

    a_ovp_holds: assert property ( // R9
        state == ST_OVP && !s.ovp_clear && !s.hot |=> state == ST_OVP [*1] ##0 !FAULT_FLAG_N_OE_N)
        else $error("overvoltage released early");

    a_short_needs_two: assert property ( // R11
        state != ST_HICCUP && next_state == ST_HICCUP |-> oc_ticks != 2'h0 && $past(s.overcurrent))
        else $error("short declared without persistence");

    a_hiccup_dim_low: assert property ( // R12
        state == ST_HICCUP && !hiccup_done |=> !DIM_SWITCH_DRIVE && !FAULT_FLAG_N_OE_N)
        else $error("dim drive on during hiccup");

    a_hiccup_retry: assert property ( // R13
        state == ST_HICCUP && hiccup_done && !s.overvoltage_sense && !s.hot |=> state == ST_SOFT_START ##1 FAULT_FLAG_N_OE_N || s.hot || s.overvoltage_sense)
        else $error("no retry after hiccup off time");

    a_thermal_hold: assert property ( // R16 R17
        s.hot |=> state == ST_THERMAL && !FAULT_FLAG_N_OE_N && STANDBY_MODE && !POWER_SWITCH_DRIVE)
        else $error("thermal shutdown not held");

    a_flag_matches_fault: assert property ( // R19
        FAULT_FLAG_N_OE_N == !is_fault(state))
        else $error("fault flag disagrees with state");

    a_low_count_clear: assert property ( // R20
        state == ST_DISABLED && en_eff |=> cycles == 16'h0)
        else $error("low count not cleared");

    c_standby_reached: cover property (state == ST_DISABLED ##1 state == ST_STANDBY);
    c_hiccup_retry: cover property (state == ST_HICCUP ##1 state == ST_SOFT_START);
    c_ovp_recover: cover property (state == ST_OVP ##1 state == ST_STANDBY);
    c_thermal_recover: cover property (state == ST_THERMAL ##1 state == ST_STANDBY);

endmodule // led_dim_enable_fault_sequencer
`default_nettype wire

// file: bench/host_side_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_side_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Switching tick toward the block
    output logic switch_tick,
    // Open-drain fault flag from the block
    input wire logic flag_out,
    input wire logic flag_oe_n,
    output logic fault_line
);
    logic [2:0] phase;

    ////////////////////////////////////////////////////////////////
    // Four cycles high, four low: above the two-cycle minimum
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase <= 3'h0;
        end else begin
            phase <= phase + 3'h1;
        end
    end
    assign switch_tick = phase[2];

    ////////////////////////////////////////////////////////////////
    // Pull-up wins when released; the host reads low as a fault
    assign fault_line = flag_oe_n ? 1'b1 : flag_out;
endmodule // host_side_model
`default_nettype wire

// file: bench/led_dim_enable_fault_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module led_dim_enable_fault_sequencer_tb;
    import dim_seq_pkg::*;
    localparam int TK = 8;
    logic CLK = 1'b0, RESET = 1'b1;
    logic [4:0] AVS_ADDRESS = 5'h00;
    logic AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
    logic [3:0] AVS_BYTEENABLE = 4'hF;
    logic AVS_WAITREQUEST, SWITCH_TICK, fault_line, flag_out, flag_oe_n;
    logic EN_DIM_PIN = 1'b1, EN_DIM_FLOAT = 1'b0, ANALOG_LEVEL_INPUT_LOW = 1'b0;
    logic OVERVOLTAGE_SENSE = 1'b0, OVERVOLTAGE_CLEAR = 1'b1, STRING_OVERCURRENT = 1'b0;
    logic TEMP_HOT = 1'b0, TEMP_COOL = 1'b1;
    logic POWER_SWITCH_DRIVE, DIM_SWITCH_DRIVE, SOFT_START_ACTIVE, STANDBY_MODE;
    int mismatches = 0, checks_done = 0, cycles = 0;

    always #25 CLK = ~CLK;

    led_dim_enable_fault_sequencer #(.STANDBY_CYCLES(16'h0008), .HICCUP_CYCLES(16'h0004)) dut (
        .CLK(CLK), .RESET(RESET),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .EN_DIM_PIN(EN_DIM_PIN), .EN_DIM_FLOAT(EN_DIM_FLOAT),
        .ANALOG_LEVEL_INPUT_LOW(ANALOG_LEVEL_INPUT_LOW), .OVERVOLTAGE_SENSE(OVERVOLTAGE_SENSE),
        .OVERVOLTAGE_CLEAR(OVERVOLTAGE_CLEAR), .STRING_OVERCURRENT(STRING_OVERCURRENT),
        .TEMP_HOT(TEMP_HOT), .TEMP_COOL(TEMP_COOL), .SWITCH_TICK(SWITCH_TICK),
        .POWER_SWITCH_DRIVE(POWER_SWITCH_DRIVE), .DIM_SWITCH_DRIVE(DIM_SWITCH_DRIVE),
        .SOFT_START_ACTIVE(SOFT_START_ACTIVE), .STANDBY_MODE(STANDBY_MODE),
        .FAULT_FLAG_N_OUT(flag_out), .FAULT_FLAG_N_OE_N(flag_oe_n)
    );

    host_side_model partner (
        .clk(CLK), .reset(RESET), .switch_tick(SWITCH_TICK),
        .flag_out(flag_out), .flag_oe_n(flag_oe_n), .fault_line(fault_line)
    );

    ////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs about 1450 cycles
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            mismatches++;
            results();
        end
    end

    task automatic chk_pin(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // Waitrequest is sampled at the rising edge; the request stands until it is seen low there
    task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_READ <= ~wr;
        AVS_WRITE <= wr;
        do begin
            @(posedge CLK);
        end while (AVS_WAITREQUEST !== 1'b0);
        r = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus_xfer(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] r);
        bus_xfer(1'b0, a, 32'h0, r);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge CLK);
        @(negedge CLK);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        settle(11);
        chk_pin(STANDBY_MODE, 1'b1);
        chk_pin(DIM_SWITCH_DRIVE, 1'b0);
        chk_pin(fault_line, 1'b1);
        @(posedge CLK) RESET <= 1'b0;
        rd(OFS_CONTROL, q);
        chk_reg(q, {30'h0, CTRL_RESET});
        rd(OFS_SOFT_START, q);
        chk_reg(q, {16'h0, SOFT_START_RESET});
        rd(5'h14, q);
        chk_reg(q, 32'h0);
        wr(OFS_STATUS, 32'hFFFFFFFF);
        rd(OFS_RETRIES, q);
        chk_reg(q, 32'h0);
        // Only the low byte lane is enabled, so the upper byte must not land
        @(posedge CLK) AVS_BYTEENABLE <= 4'h1;
        wr(OFS_SOFT_START, 32'h0000AB02);
        AVS_BYTEENABLE <= 4'hF;
        rd(OFS_SOFT_START, q);
        chk_reg(q, 32'h00000002);
        $display("test registers done");
        settle(600);
        chk_pin(DIM_SWITCH_DRIVE, 1'b1);
        chk_pin(POWER_SWITCH_DRIVE, 1'b1);
        chk_pin(SOFT_START_ACTIVE, 1'b0);
        chk_pin(STANDBY_MODE, 1'b0);
        @(posedge CLK) EN_DIM_PIN <= 1'b0;
        settle(8);
        chk_pin(DIM_SWITCH_DRIVE, 1'b0);
        settle(6 * TK);
        @(posedge CLK) EN_DIM_PIN <= 1'b1;
        settle(6);
        @(posedge CLK) EN_DIM_PIN <= 1'b0;
        settle(6 * TK);
        chk_pin(STANDBY_MODE, 1'b0);
        settle(5 * TK);
        chk_pin(STANDBY_MODE, 1'b1);
        @(posedge CLK) EN_DIM_PIN <= 1'b1;
        settle(8);
        chk_pin(SOFT_START_ACTIVE, 1'b1);
        settle(6 * TK);
        chk_pin(DIM_SWITCH_DRIVE, 1'b1);
        $display("test enable done");
        @(posedge CLK) EN_DIM_PIN <= 1'b0;
        EN_DIM_FLOAT <= 1'b1;
        settle(8);
        chk_pin(DIM_SWITCH_DRIVE, 1'b1);
        @(posedge CLK) EN_DIM_PIN <= 1'b1;
        EN_DIM_FLOAT <= 1'b0;
        settle(4 * TK);
        @(posedge CLK) ANALOG_LEVEL_INPUT_LOW <= 1'b1;
        settle(8);
        chk_pin(DIM_SWITCH_DRIVE, 1'b0);
        chk_pin(POWER_SWITCH_DRIVE, 1'b0);
        @(posedge CLK) ANALOG_LEVEL_INPUT_LOW <= 1'b0;
        settle(8);
        chk_pin(DIM_SWITCH_DRIVE, 1'b1);
        $display("test float and analog done");
        @(posedge CLK) OVERVOLTAGE_SENSE <= 1'b1;
        OVERVOLTAGE_CLEAR <= 1'b0;
        settle(8);
        chk_pin(DIM_SWITCH_DRIVE, 1'b0);
        chk_pin(POWER_SWITCH_DRIVE, 1'b0);
        chk_pin(fault_line, 1'b0);
        @(posedge CLK) OVERVOLTAGE_SENSE <= 1'b0;
        settle(4 * TK);
        chk_pin(fault_line, 1'b0);
        chk_pin(DIM_SWITCH_DRIVE, 1'b0);
        rd(OFS_STATUS, q);
        chk_reg(q, 32'h00000055);
        @(posedge CLK) OVERVOLTAGE_CLEAR <= 1'b1;
        settle(8);
        chk_pin(fault_line, 1'b1);
        settle(6 * TK);
        chk_pin(DIM_SWITCH_DRIVE, 1'b1);
        $display("test overvoltage done");
        // One tick edge at most inside this pulse: too short for a short
        @(posedge CLK) STRING_OVERCURRENT <= 1'b1;
        settle(5);
        @(posedge CLK) STRING_OVERCURRENT <= 1'b0;
        settle(3 * TK);
        chk_pin(fault_line, 1'b1);
        @(posedge CLK) STRING_OVERCURRENT <= 1'b1;
        settle(3 * TK);
        chk_pin(DIM_SWITCH_DRIVE, 1'b0);
        chk_pin(fault_line, 1'b0);
        settle(14 * TK);
        rd(OFS_RETRIES, q);
        chk_pin(q >= 32'h2 && q <= 32'h3, 1'b1);
        @(posedge CLK) STRING_OVERCURRENT <= 1'b0;
        settle(12 * TK);
        chk_pin(DIM_SWITCH_DRIVE, 1'b1);
        chk_pin(fault_line, 1'b1);
        wr(OFS_CONTROL, 32'h0);
        @(posedge CLK) STRING_OVERCURRENT <= 1'b1;
        settle(4 * TK);
        chk_pin(DIM_SWITCH_DRIVE, 1'b1);
        @(posedge CLK) STRING_OVERCURRENT <= 1'b0;
        wr(OFS_CONTROL, 32'h3);
        $display("test short done");
        @(posedge CLK) TEMP_HOT <= 1'b1;
        TEMP_COOL <= 1'b0;
        settle(8);
        chk_pin(STANDBY_MODE, 1'b1);
        chk_pin(fault_line, 1'b0);
        chk_pin(DIM_SWITCH_DRIVE, 1'b0);
        @(posedge CLK) TEMP_HOT <= 1'b0;
        settle(4 * TK);
        chk_pin(STANDBY_MODE, 1'b1);
        @(posedge CLK) TEMP_COOL <= 1'b1;
        settle(8 * TK);
        chk_pin(STANDBY_MODE, 1'b0);
        chk_pin(fault_line, 1'b1);
        chk_pin(DIM_SWITCH_DRIVE, 1'b1);
        rd(OFS_STATUS, q);
        chk_reg(q, 32'h00000012);
        rd(OFS_EVENTS, q);
        chk_reg(q, 32'h0000000F);
        wr(OFS_EVENTS, 32'h0000000F);
        rd(OFS_EVENTS, q);
        chk_reg(q, 32'h0);
        $display("test thermal done");
        results();
    end
endmodule // led_dim_enable_fault_sequencer_tb
`default_nettype wire
